// ==== handler_model.sv ====
`timescale 1ns/100ps
module handler_model
  import ts_io_pkg::*;
#(
  parameter int unsigned LOW_CYC = 130
) (
  // Clock and reset
  input  wire logic    ref_clk_i,
  input  wire logic    reset_i,
  // Commands from the bench
  input  wire logic    fire_i,
  input  wire nibble_t c_drv_i,
  input  wire nibble_t d_drv_i,
  output logic         busy_o,
  // Device pins
  output logic         trig_n_o,
  input  wire nibble_t c_out_i,
  input  wire nibble_t c_oe_i,
  input  wire nibble_t d_out_i,
  input  wire nibble_t d_oe_i,
  output nibble_t      c_pin_o,
  output nibble_t      d_pin_o
);
  int unsigned low_cnt_q;

  // Trigger held low a little over 1us, never shorter
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      low_cnt_q <= 0;
    end else if (fire_i && low_cnt_q == 0) begin
      low_cnt_q <= LOW_CYC;
    end else if (low_cnt_q != 0) begin
      low_cnt_q <= low_cnt_q - 1;
    end
  end

  // Released trigger line is pulled up
  assign trig_n_o = (low_cnt_q == 0);
  assign busy_o   = (low_cnt_q != 0);
  // Shared wire: the device wins where it drives, else the handler
  assign c_pin_o  = (c_oe_i & c_out_i) | (~c_oe_i & c_drv_i);
  assign d_pin_o  = (d_oe_i & d_out_i) | (~d_oe_i & d_drv_i);
endmodule

// ==== min_pulse_gen.sv ====
`timescale 1ns/100ps
module min_pulse_gen
  import ts_io_pkg::*;
#(
  parameter int unsigned CYCLES = 125,
  parameter int unsigned CNT_W  = 11
) (
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic reset_i,
  // Trigger and pulse
  input  wire logic start_i,
  output logic      pulse_n_o,
  output logic      done_o
);

  logic [CNT_W-1:0] cnt_q;
  logic             pulse_n_q;
  logic             done_q;

  // A new start during a pulse restarts the full width
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_q     <= '0;
      pulse_n_q <= 1'b1;
      done_q    <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start_i) begin
        cnt_q     <= CNT_W'(CYCLES - 1);
        pulse_n_q <= 1'b0;
      end else if (!pulse_n_q) begin
        if (cnt_q == '0) begin
          pulse_n_q <= 1'b1;
          done_q    <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 1'b1;
        end
      end
    end
  end

  assign pulse_n_o = pulse_n_q;
  assign done_o    = done_q;

endmodule

// ==== tb_top.sv ====
`timescale 1ns/100ps
module tb_top
  import ts_io_pkg::*;
;
  logic        ref_clk, reset, wr, rd, sweep_done, fire, hbusy, trig_n;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, d;
  nibble_t     c_drv, d_drv, c_pin, d_pin, c_out, c_oe, d_out, d_oe;
  nibble_t     tc, td, exp_c, exp_d;
  logic        c_st, d_st, ds_n, pf, pfs_n, se_n, irq;
  logic [1:0]  aux, stage;
  byte_t       pa, pb, exp_a, exp_b;
  int          fails, checks_done, n;

  test_set_io_port u_dut (
    .ref_clk_i(ref_clk), .reset_i(reset), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .sweep_done_i(sweep_done),
    .latch_trigger_in_i(trig_n), .aux_latched_out_o(aux),
    .first_byte_out_port_o(pa), .second_byte_out_port_o(pb),
    .port_c_in_i(c_pin), .port_c_out_o(c_out), .port_c_oe_o(c_oe),
    .port_c_status_o(c_st), .port_d_in_i(d_pin), .port_d_out_o(d_out),
    .port_d_oe_o(d_oe), .port_d_status_o(d_st), .data_strobe_n_o(ds_n),
    .pass_fail_o(pf), .pf_strobe_n_o(pfs_n), .sweep_end_n_o(se_n),
    .irq_o(irq));

  handler_model u_handler (
    .ref_clk_i(ref_clk), .reset_i(reset), .fire_i(fire), .c_drv_i(c_drv),
    .d_drv_i(d_drv), .busy_o(hbusy), .trig_n_o(trig_n), .c_out_i(c_out),
    .c_oe_i(c_oe), .d_out_i(d_out), .d_oe_i(d_oe), .c_pin_o(c_pin),
    .d_pin_o(d_pin));

  initial ref_clk = 1'b0;
  always #4 ref_clk = ~ref_clk;

  task automatic close_out;
    if (fails == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge ref_clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  function automatic logic sig_of(input int w);
    case (w)
      0: return ds_n;
      1: return pfs_n;
      default: return se_n;
    endcase
  endfunction

  // Counts low cycles; bounded so a stuck strobe cannot hang the run
  task automatic low_width(input int w, output int cnt);
    cnt = 0;
    while (sig_of(w) === 1'b0 && cnt < 3000) begin
      cnt++;
      @(posedge ref_clk);
      #1;
    end
  endtask

  initial begin
    #400000;
    fails++;
    close_out();
  end

  initial begin
    fails = 0; checks_done = 0; wr = 0; rd = 0; addr = 0; wdata = 0;
    sweep_done = 0; fire = 0; c_drv = 4'hA; d_drv = 4'h5; reset = 1;
    void'($urandom(85188));
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    #1;
    chk("rst_strobes", 32'h7, {ds_n, pfs_n, se_n});
    chk("rst_ports", 32'h0, {pa, pb, c_oe, d_oe, c_st, d_st, aux, irq});
    chk("rst_pf", 32'h1, pf);
    exp_a = byte_t'($urandom);
    exp_b = byte_t'($urandom);
    wr_reg(8'h00, {24'h0, exp_a});
    chk("port_a", exp_a, pa);
    chk("strobe_low", 32'h0, ds_n);
    wr_reg(8'h04, {24'h0, exp_b});
    low_width(0, n);
    chk("data_strobe_w", 125, n);
    chk("ports_held", {exp_a, exp_b}, {pa, pb});
    wr_reg(8'h30, $urandom);
    rd_reg(8'h30, d);
    chk("unmapped", 32'h0, d);
    rd_reg(8'h00, d);
    chk("rd_port_a", exp_a, d);
    for (int i = 0; i < 4; i++) begin
      tc = nibble_t'($urandom);
      td = nibble_t'($urandom);
      exp_c = nibble_t'($urandom);
      exp_d = nibble_t'($urandom);
      @(posedge ref_clk);
      c_drv <= tc;
      d_drv <= td;
      wr_reg(8'h10, i);
      wr_reg(8'h08, exp_c);
      wr_reg(8'h0C, exp_d);
      chk("status", i, {d_st, c_st});
      chk("oe", {{4{i[1]}}, {4{i[0]}}}, {d_oe, c_oe});
      if (i == 3) chk("cd_out", {exp_d, exp_c}, {d_out, c_out});
      repeat (2) @(posedge ref_clk);
      rd_reg(8'h14, d);
      chk("pins", {i[1] ? exp_d : td, i[0] ? exp_c : tc}, d);
    end
    low_width(0, n);
    for (int i = 0; i < 4; i++) begin
      wr_reg(8'h18, i);
      chk("pass_fail", 1'(i[1] ? i[0] : ~i[0]), pf);
      low_width(1, n);
      chk("pf_strobe_w", 125, n);
    end
    @(posedge ref_clk);
    sweep_done <= 1'b1;
    @(posedge ref_clk);
    sweep_done <= 1'b0;
    #1;
    low_width(2, n);
    chk("sweep_w", 1250, n);
    wr_reg(8'h20, 32'h1);
    low_width(2, n);
    chk("sweep_go_w", 1250, n);
    stage = 2'($urandom);
    for (int i = 0; i < 2; i++) begin
      wr_reg(8'h1C, i ? ~stage : stage);
      chk("aux_held", i ? stage : 2'h0, aux);
      @(posedge ref_clk);
      fire <= 1'b1;
      @(posedge ref_clk);
      fire <= 1'b0;
      #1;
      repeat (200) if (hbusy) @(posedge ref_clk);
      #1;
      chk("aux_latch", 2'(i ? ~stage : stage), aux);
    end
    // Every event has fired at least once by now, so all four sticky bits are set
    rd_reg(8'h24, d);
    chk("irq_stat", 32'hF, d);
    chk("irq_masked", 32'h0, irq);
    wr_reg(8'h28, 32'h1);
    chk("irq_on", 32'h1, irq);
    wr_reg(8'h24, 32'h1);
    rd_reg(8'h24, d);
    chk("irq_w1c", 32'hE, d);
    chk("irq_off", 32'h0, irq);
    wr_reg(8'h28, 32'hE);
    chk("irq_rest", 32'h1, irq);
    wr_reg(8'h24, 32'hF);
    chk("irq_clr", 32'h0, irq);
    close_out();
  end
endmodule

// ==== test_set_io_port.sv ====
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`include "ts_io_cfg.svh"

// Contract
// - Trigger low pulse latches both aux outputs
// - Bidir port status low input, high output
// - Port data update gives low strobe, 1us
// - Latched pass/fail pin, software-chosen pass level
// - Sweep complete drives sweep end low 10us
// - Pass/fail update gives own 1us low strobe
module test_set_io_port
  import ts_io_pkg::*;
(
  // Clock and reset
  input  wire logic                  ref_clk_i,
  input  wire logic                  reset_i,
  // Register port
  input  wire logic [`TS_ADDR_W-1:0] addr_i,
  input  wire logic [`TS_DATA_W-1:0] wdata_i,
  input  wire logic                  wr_i,
  input  wire logic                  rd_i,
  output logic      [`TS_DATA_W-1:0] rdata_o,
  // Measurement engine
  input  wire logic                  sweep_done_i,
  // Latch trigger and aux outputs
  input  wire logic                  latch_trigger_in_i,
  output logic      [1:0]            aux_latched_out_o,
  // Byte output ports
  output logic      [7:0]            first_byte_out_port_o,
  output logic      [7:0]            second_byte_out_port_o,
  // Bidirectional nibble ports
  input  wire logic [3:0]            port_c_in_i,
  output logic      [3:0]            port_c_out_o,
  output logic      [3:0]            port_c_oe_o,
  output logic                       port_c_status_o,
  input  wire logic [3:0]            port_d_in_i,
  output logic      [3:0]            port_d_out_o,
  output logic      [3:0]            port_d_oe_o,
  output logic                       port_d_status_o,
  // Strobes and flags
  output logic                       data_strobe_n_o,
  output logic                       pass_fail_o,
  output logic                       pf_strobe_n_o,
  output logic                       sweep_end_n_o,
  // Interrupt
  output logic                       irq_o
);

  localparam int STROBE_CYC_I = `TS_STROBE_CYC;
  localparam int SWEEP_CYC_I  = `TS_SWEEP_CYC;

  byte_t      port_a_q;
  byte_t      port_b_q;
  nibble_t    port_nib_q [2];
  logic [1:0] dir_q;
  pass_fail_s pf_q;
  logic       pf_pin_q;
  logic [1:0] aux_src_q;
  logic [1:0] aux_q;
  irq_s       irq_stat_q;
  irq_s       irq_mask_q;
  irq_s       irq_set;
  logic [`TS_DATA_W-1:0] rdata_q;
  logic [7:0] pin_meta_q;
  logic [7:0] pin_sync_q;
  logic       trig_meta_q;
  logic       trig_sync_q;
  logic       trig_prev_q;
  logic       trig_fall;
  logic       wr_a;
  logic       wr_b;
  logic       wr_c;
  logic       wr_d;
  logic       wr_pf;
  logic       wr_sweep;
  logic       data_start;
  logic       sweep_start;
  logic       data_done;
  logic       pf_done;
  logic       sweep_done_evt;
  bidir_s     bidir [2];

  // Write decode
  assign wr_a     = wr_i && (addr_i == `TS_OFF_PORT_A);
  assign wr_b     = wr_i && (addr_i == `TS_OFF_PORT_B);
  assign wr_c     = wr_i && (addr_i == `TS_OFF_PORT_C);
  assign wr_d     = wr_i && (addr_i == `TS_OFF_PORT_D);
  assign wr_pf    = wr_i && (addr_i == `TS_OFF_PASS_FAIL);
  assign wr_sweep = wr_i && (addr_i == `TS_OFF_SWEEP)
                    && wdata_i[`TS_SWEEP_GO_BIT];

  // Output port latches
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      port_a_q      <= `TS_RST_BYTE;
      port_b_q      <= `TS_RST_BYTE;
      port_nib_q[0] <= `TS_RST_NIBBLE;
      port_nib_q[1] <= `TS_RST_NIBBLE;
      dir_q         <= `TS_RST_DIR;
    end else begin
      if (wr_a) begin
        port_a_q <= wdata_i[7:0];
      end
      if (wr_b) begin
        port_b_q <= wdata_i[7:0];
      end
      if (wr_c) begin
        port_nib_q[0] <= wdata_i[3:0];
      end
      if (wr_d) begin
        port_nib_q[1] <= wdata_i[3:0];
      end
      if (wr_i && (addr_i == `TS_OFF_DIR)) begin
        dir_q <= wdata_i[1:0];
      end
    end
  end

  assign first_byte_out_port_o  = port_a_q;
  assign second_byte_out_port_o = port_b_q;

  // Nibble ports: enable and status follow the direction bit
  for (genvar p = 0; p < 2; p++) begin : g_bidir
    assign bidir[p].dout   = port_nib_q[p];
    assign bidir[p].oe     = {4{dir_q[p]}};
    assign bidir[p].status = dir_q[p];
  end

  assign port_c_out_o    = bidir[0].dout;
  assign port_c_oe_o     = bidir[0].oe;
  assign port_c_status_o = bidir[0].status;
  assign port_d_out_o    = bidir[1].dout;
  assign port_d_oe_o     = bidir[1].oe;
  assign port_d_status_o = bidir[1].status;

  // Pin synchronisers; trigger idles high
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pin_meta_q  <= 8'h00;
      pin_sync_q  <= 8'h00;
      trig_meta_q <= 1'b1;
      trig_sync_q <= 1'b1;
      trig_prev_q <= 1'b1;
    end else begin
      pin_meta_q  <= {port_d_in_i, port_c_in_i};
      pin_sync_q  <= pin_meta_q;
      trig_meta_q <= latch_trigger_in_i;
      trig_sync_q <= trig_meta_q;
      trig_prev_q <= trig_sync_q;
    end
  end

  assign trig_fall = trig_prev_q && !trig_sync_q;

  // Aux outputs latch the staged value on the trigger's falling edge
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      aux_src_q <= `TS_RST_AUX;
      aux_q     <= `TS_RST_AUX;
    end else begin
      if (wr_i && (addr_i == `TS_OFF_AUX)) begin
        aux_src_q <= wdata_i[1:0];
      end
      if (trig_fall) begin
        aux_q <= aux_src_q;
      end
    end
  end

  assign aux_latched_out_o = aux_q;

  // Pass/fail result and polarity; pin is registered
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pf_q     <= '0;
      pf_pin_q <= 1'b1;
    end else if (wr_pf) begin
      pf_q.result   <= wdata_i[`TS_PF_RESULT_BIT];
      pf_q.polarity <= wdata_i[`TS_PF_POL_BIT];
      pf_pin_q      <= ~(wdata_i[`TS_PF_RESULT_BIT]
                         ^ wdata_i[`TS_PF_POL_BIT]);
    end
  end

  assign pass_fail_o = pf_pin_q;

  // Strobes: data writes, pass/fail writes, sweep end
  assign data_start  = wr_a || wr_b || wr_c || wr_d;
  assign sweep_start = sweep_done_i || wr_sweep;

  min_pulse_gen #(
    .CYCLES (STROBE_CYC_I),
    .CNT_W  (`TS_CNT_W)
  ) u_data_strobe (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .start_i   (data_start),
    .pulse_n_o (data_strobe_n_o),
    .done_o    (data_done)
  );

  min_pulse_gen #(
    .CYCLES (STROBE_CYC_I),
    .CNT_W  (`TS_CNT_W)
  ) u_pf_strobe (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .start_i   (wr_pf),
    .pulse_n_o (pf_strobe_n_o),
    .done_o    (pf_done)
  );

  min_pulse_gen #(
    .CYCLES (SWEEP_CYC_I),
    .CNT_W  (`TS_CNT_W)
  ) u_sweep_end (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .start_i   (sweep_start),
    .pulse_n_o (sweep_end_n_o),
    .done_o    (sweep_done_evt)
  );

  // Interrupts: set wins over a write-one clear in the same cycle
  assign irq_set = '{sweep_done:       sweep_done_evt,
                     pf_strobe_done:   pf_done,
                     data_strobe_done: data_done,
                     trigger:          trig_fall};

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_stat_q <= `TS_RST_IRQ;
      irq_mask_q <= `TS_RST_IRQ;
    end else begin
      if (wr_i && (addr_i == `TS_OFF_IRQ_STAT)) begin
        irq_stat_q <= (irq_stat_q & ~irq_s'(wdata_i[3:0])) | irq_set;
      end else begin
        irq_stat_q <= irq_stat_q | irq_set;
      end
      if (wr_i && (addr_i == `TS_OFF_IRQ_MASK)) begin
        irq_mask_q <= wdata_i[3:0];
      end
    end
  end

  assign irq_o = |(irq_stat_q & irq_mask_q);

  // Read data one cycle after the strobe; zero otherwise
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= '0;
      if (rd_i) begin
        case (addr_i)
          `TS_OFF_PORT_A:    rdata_q[7:0] <= port_a_q;
          `TS_OFF_PORT_B:    rdata_q[7:0] <= port_b_q;
          `TS_OFF_PORT_C:    rdata_q[3:0] <= port_nib_q[0];
          `TS_OFF_PORT_D:    rdata_q[3:0] <= port_nib_q[1];
          `TS_OFF_DIR:       rdata_q[1:0] <= dir_q;
          `TS_OFF_PIN_IN:    rdata_q[7:0] <= pin_sync_q;
          `TS_OFF_PASS_FAIL: rdata_q[1:0] <= pf_q;
          `TS_OFF_AUX:       rdata_q[3:0] <= {aux_q, aux_src_q};
          `TS_OFF_SWEEP:     rdata_q[2:0] <= {~sweep_end_n_o,
                                              ~pf_strobe_n_o,
                                              ~data_strobe_n_o};
          `TS_OFF_IRQ_STAT:  rdata_q[3:0] <= irq_stat_q;
          `TS_OFF_IRQ_MASK:  rdata_q[3:0] <= irq_mask_q;
          default:           rdata_q <= '0;
        endcase
      end
    end
  end

  assign rdata_o = rdata_q;

  // Low-time counters seen only by the checks below
  logic [15:0] data_low_q;
  logic [15:0] pf_low_q;
  logic [15:0] sweep_low_q;

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      data_low_q  <= '0;
      pf_low_q    <= '0;
      sweep_low_q <= '0;
    end else begin
      data_low_q  <= data_strobe_n_o ? 16'h0000 : data_low_q + 16'h0001;
      pf_low_q    <= pf_strobe_n_o ? 16'h0000 : pf_low_q + 16'h0001;
      sweep_low_q <= sweep_end_n_o ? 16'h0000 : sweep_low_q + 16'h0001;
    end
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);

  sequence trig_seen_s;
    trig_fall;
  endsequence

  sequence port_write_s;
    wr_i && (addr_i == `TS_OFF_PORT_A);
  endsequence

  aux_trigger_latch_a: assert property (
    trig_seen_s |=> aux_latched_out_o == $past(aux_src_q))
    else $error("aux outputs did not latch on trigger");

  aux_hold_a: assert property (
    !trig_fall |=> $stable(aux_latched_out_o))
    else $error("aux outputs changed without trigger");

  // Checks the written direction, not just that status mirrors enable
  dir_status_a: assert property (
    wr_i && (addr_i == `TS_OFF_DIR) |=>
      {port_d_status_o, port_c_status_o} == $past(wdata_i[1:0])
      && port_c_oe_o == {4{port_c_status_o}}
      && port_d_oe_o == {4{port_d_status_o}})
    else $error("port status disagrees with direction write");

  data_strobe_go_a: assert property (
    port_write_s |=> !data_strobe_n_o ##1 !data_strobe_n_o)
    else $error("data strobe did not start after port write");

  data_strobe_width_a: assert property (
    $rose(data_strobe_n_o) |-> data_low_q >= STROBE_CYC_I)
    else $error("data strobe shorter than minimum");

  pf_polarity_a: assert property (
    wr_pf |=> pass_fail_o == (pf_q.result ~^ pf_q.polarity))
    else $error("pass/fail pin has wrong level");

  sweep_end_a: assert property (
    sweep_done_i |=> !sweep_end_n_o ##1 !sweep_end_n_o)
    else $error("sweep end did not go low");

  sweep_width_a: assert property (
    $rose(sweep_end_n_o) |-> sweep_low_q >= SWEEP_CYC_I)
    else $error("sweep end pulse shorter than minimum");

  pf_strobe_width_a: assert property (
    $rose(pf_strobe_n_o) |-> pf_low_q >= STROBE_CYC_I)
    else $error("pass/fail strobe shorter than minimum");

  pf_strobe_go_a: assert property (
    wr_pf |=> !pf_strobe_n_o)
    else $error("pass/fail strobe did not start");

  port_hold_a: assert property (
    !port_write_s |=> $stable(first_byte_out_port_o))
    else $error("byte port changed without a write");

endmodule

// ==== ts_io_cfg.svh ====
`ifndef TS_IO_CFG_SVH
`define TS_IO_CFG_SVH

// Clock and pulse timing
`define TS_CLK_MHZ        125
`define TS_STROBE_MIN_NS  1000
`define TS_SWEEP_MIN_NS   10000
`define TS_STROBE_CYC     ((`TS_STROBE_MIN_NS * `TS_CLK_MHZ + 999) / 1000)
`define TS_SWEEP_CYC      ((`TS_SWEEP_MIN_NS * `TS_CLK_MHZ + 999) / 1000)
`define TS_CNT_W          11

// Register bus
`define TS_ADDR_W         8
`define TS_DATA_W         32

// Register offsets
`define TS_OFF_PORT_A     8'h00
`define TS_OFF_PORT_B     8'h04
`define TS_OFF_PORT_C     8'h08
`define TS_OFF_PORT_D     8'h0C
`define TS_OFF_DIR        8'h10
`define TS_OFF_PIN_IN     8'h14
`define TS_OFF_PASS_FAIL  8'h18
`define TS_OFF_AUX        8'h1C
`define TS_OFF_SWEEP      8'h20
`define TS_OFF_IRQ_STAT   8'h24
`define TS_OFF_IRQ_MASK   8'h28

// Field positions
`define TS_PF_RESULT_BIT  0
`define TS_PF_POL_BIT     1
`define TS_SWEEP_GO_BIT   0

// Reset values
`define TS_RST_BYTE       8'h00
`define TS_RST_NIBBLE     4'h0
`define TS_RST_DIR        2'h0
`define TS_RST_AUX        2'h0
`define TS_RST_IRQ        4'h0

`endif

// ==== ts_io_pkg.sv ====
package ts_io_pkg;

  typedef logic [7:0] byte_t;
  typedef logic [3:0] nibble_t;

  // Pass/fail configuration and result
  typedef struct packed {
    logic polarity;
    logic result;
  } pass_fail_s;

  // Interrupt sources, one bit each
  typedef struct packed {
    logic sweep_done;
    logic pf_strobe_done;
    logic data_strobe_done;
    logic trigger;
  } irq_s;

  // One bidirectional nibble port towards the pins
  typedef struct packed {
    nibble_t dout;
    nibble_t oe;
    logic    status;
  } bidir_s;

endpackage
